//--- include/rst_comb_pkg.sv
// Package for the reset source combiner and its cause/control register.
// Assumes a single system clock domain; used by both design files.
package rst_comb_pkg;

    // Register map (word index on the plain register port)
    localparam logic [3:0]  ADDR_CAUSE_CTRL = 4'h0;
    localparam logic [3:0]  ADDR_SOURCES    = 4'h1;

    // Bit positions in the cause/control register
    localparam int BIT_TRAP    = 15;
    localparam int BIT_ILLEGAL = 14;
    localparam int BIT_SBOREN  = 13;
    localparam int BIT_RETEN   = 12;
    localparam int BIT_CFGMIS  = 9;
    localparam int BIT_PMSLP   = 8;
    localparam int BIT_PIN     = 7;
    localparam int BIT_SWRST   = 6;
    localparam int BIT_SWWDT   = 5;
    localparam int BIT_WDT_TIMEOUT = 4;
    localparam int BIT_SLEEP   = 3;
    localparam int BIT_IDLE    = 2;
    localparam int BIT_BROWN   = 1;
    localparam int BIT_POWERON = 0;

    // Implemented bits; 11 and 10 read as zero
    localparam logic [15:0] CAUSE_IMPL_MASK = 16'hF3FF;
    // Value after power-on: only brown-out and power-on flags set
    localparam logic [15:0] CAUSE_POR_VAL   = 16'h0003;
    // Unprogrammed watchdog fuse value
    localparam logic [1:0]  WDT_FUSE_ALWAYS = 2'h3;

    // Cycles the master reset stays high, counted from the last cycle a source is seen active
    localparam int RST_STRETCH_CYC = 4;

    // Reset requests, one bit each
    typedef struct packed {
        logic poweron;
        logic pin;
        logic sw_instr;
        logic watchdog;
        logic brownout;
        logic lp_brownout;
        logic trap_conflict;
        logic illegal_opcode;
        logic uninit_wreg;
        logic cfg_mismatch;
    } reset_req_t;

    // Power-save instruction events from the CPU
    typedef struct packed {
        logic sleep;
        logic idle;
    } power_save_t;

    // Register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage

//--- verif/reset_source_combiner_status_test.sv
// Self-checking bench for the reset combiner and its cause register.
// Assumes the design package and the request model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module reset_source_combiner_status_test;
    import rst_comb_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        go = 1'b0;
    logic [3:0]  sel = 4'h0;
    reset_req_t  reset_req;
    power_save_t pwr = '0;
    logic [1:0]  fuse = 2'h0;
    reg_req_t    reg_req = '0;
    logic [15:0] rdata;
    logic        msr, wde, sbe, rte, pms, rd_seen = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] flag_tab[10] = '{16'h0003, 16'h0080, 16'h0040, 16'h0010,
        16'h0002, 16'h0002, 16'h8000, 16'h4000, 16'h4000, 16'h0200};
    logic [15:0] d;
    logic [15:0] exp_v;
    int          num_errors = 0;
    int          comparisons = 0;

    always #20 mclk = ~mclk;

    reset_source_model u_src (.mclk(mclk), .go(go), .sel(sel),
        .reset_req(reset_req));
    reset_source_combiner_status #(.STRETCH(1)) u_dut (
        .mclk(mclk), .rst(rst), .reset_req(reset_req),
        .power_save_instruction(pwr), .watchdog_config_fuse(fuse),
        .reg_req(reg_req), .rdata(rdata), .master_system_reset(msr),
        .watchdog_enable(wde), .sbor_enable(sbe),
        .retention_enable(rte), .pm_sleep_ctrl(pms));

    ////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe
    always @(posedge mclk) begin
        rd_seen <= reg_req.rd;
        if (rd_seen) begin
            exp_v = exp_q.pop_front();
            `CHK("rdata", exp_v, rdata)
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge mclk);
        reg_req.rd <= 1'b0;
    endtask

    // Bounded wait for the master reset to reach a level
    task automatic wait_msr(input logic v);
        for (int n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (msr === v) begin
                return;
            end
        end
        $display("CHECK FAILED master_system_reset exp %h got %h", v, msr);
        num_errors++;
        conclude();
    endtask

    task automatic pulse(input power_save_t p);
        @(posedge mclk);
        pwr <= p;
        @(posedge mclk);
        pwr <= '0;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(81));
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        `CHK("msr_after_por", 1'b1, msr)
        rd(ADDR_CAUSE_CTRL, CAUSE_POR_VAL);
        wait_msr(1'b0);
        $display("test power_on done");
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(ADDR_CAUSE_CTRL, d);
            rd(ADDR_CAUSE_CTRL, d & CAUSE_IMPL_MASK);
            `CHK("msr_after_write", 1'b0, msr)
        end
        rd(4'h7, 16'h0000);
        $display("test software_write done");
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_CAUSE_CTRL, 16'h0000);
            @(posedge mclk);
            go <= 1'b1;
            sel <= 4'(i);
            @(posedge mclk);
            go <= 1'b0;
            wait_msr(1'b1);
            rd(ADDR_SOURCES, 16'h0200 >> i);
            wr(ADDR_CAUSE_CTRL, 16'h0000);
            wait_msr(1'b0);
            rd(ADDR_CAUSE_CTRL, flag_tab[i]);
        end
        $display("test sources done");
        wr(ADDR_CAUSE_CTRL, 16'h0010);
        pulse('{sleep: 1'b1, idle: 1'b0});
        rd(ADDR_CAUSE_CTRL, 16'h0008);
        pulse('{sleep: 1'b0, idle: 1'b1});
        rd(ADDR_CAUSE_CTRL, 16'h000C);
        $display("test power_save done");
        wr(ADDR_CAUSE_CTRL, 16'h0000);
        fuse <= WDT_FUSE_ALWAYS;
        repeat (3) @(posedge mclk);
        `CHK("wdt_fuse", 1'b1, wde)
        fuse <= 2'h0;
        repeat (3) @(posedge mclk);
        `CHK("wdt_off", 1'b0, wde)
        wr(ADDR_CAUSE_CTRL, 16'h3120);
        repeat (3) @(posedge mclk);
        `CHK("ctrl", 4'hF, {wde, sbe, rte, pms})
        $display("test control done");
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        `CHK("ctrl_por", 4'h0, {wde, sbe, rte, pms})
        `CHK("msr_por", 1'b1, msr)
        rst <= 1'b0;
        rd(ADDR_CAUSE_CTRL, CAUSE_POR_VAL);
        wait_msr(1'b0);
        $display("test power_on_again done");
        repeat (3) @(posedge mclk);
        conclude();
    end
endmodule

//--- verif/reset_source_model.sv
// Far-side model: pin, watchdog, brown-out and CPU trap request lines.
// Assumes a one-cycle go pulse on mclk that picks one request by index.
`timescale 1ns/1ps
module reset_source_model
    import rst_comb_pkg::*;
(
    // Clock
    input  wire logic       mclk,
    // Control from the bench
    input  wire logic       go,
    input  wire logic [3:0] sel,
    // Requests toward the block
    output reset_req_t      reset_req
);
    logic [3:0] left_r = 4'h0;
    logic [9:0] bits_r = 10'h000;
    // Released lines fall back to inactive, as a driven-low source would
    assign reset_req = reset_req_t'((left_r != 4'h0) ? bits_r : 10'h000);
    always @(posedge mclk) begin
        if (go) begin
            bits_r <= 10'h200 >> sel;
            left_r <= 4'hA;
        end else if (left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
        end
    end
endmodule

//--- verilog/req_sync.sv
// Two-flop synchroniser bank for asynchronous reset requests.
// Assumes inputs are levels from outside the mclk domain.
`timescale 1ns/1ps
module req_sync
    import rst_comb_pkg::*;
#(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

//--- verilog/reset_source_combiner_status.sv
// Reset source combiner with the reset cause and control register.
// Assumes rst is the power-on reset; sources are async levels.
//
// Operation
// - Combine all reset requests into master reset
// - Accept ten listed reset sources
// - Any active source asserts master reset
// - Some registers forced by reset, others kept
// - Each reset type sets its own flag
// - Power-on clears all, sets low two flags
// - Software may write any flag anytime
// - Software flag writes never cause reset
// - Register holds watchdog and power-save bits
// - Power-save instruction clears watchdog flag
// - Sleep and idle flags set by instruction
// - Brown-out flag set by brown-out or power-on
// - Unprogrammed fuse keeps watchdog always enabled
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module reset_source_combiner_status
    import rst_comb_pkg::*;
#(
    parameter int STRETCH = RST_STRETCH_CYC
) (
    // Clock and power-on reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Reset requests from pins and other logic
    input  wire reset_req_t  reset_req,
    // Power-save instruction events (same clock)
    input  wire power_save_t power_save_instruction,
    // Watchdog configuration fuse
    input  wire logic [1:0]  watchdog_config_fuse,
    // Register port
    input  wire reg_req_t    reg_req,
    output logic      [15:0] rdata,
    // Results
    output logic             master_system_reset,
    output logic             watchdog_enable,
    output logic             sbor_enable,
    output logic             retention_enable,
    output logic             pm_sleep_ctrl
);

    ////////////////////////////////////////////////////////////////////
    // Request synchronisation and combining

    reset_req_t  req_s;
    logic        any_req;
    logic [2:0]  stretch_r;
    logic [2:0]  stretch_nxt;

    req_sync #(
        .WIDTH ($bits(reset_req_t))
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  (reset_req),
        .dout (req_s)
    );

    assign any_req = |req_s;

    // Master reset held a few cycles so every listener sees it
    assign stretch_nxt = any_req ? 3'(STRETCH) :
                         (stretch_r != 3'h0) ? stretch_r - 3'h1 : 3'h0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            stretch_r           <= 3'(STRETCH);
            master_system_reset <= 1'b1;
        end else begin
            stretch_r           <= stretch_nxt;
            master_system_reset <= any_req || (stretch_nxt != 3'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Cause and control register

    logic [15:0] cause_r;
    logic [15:0] cause_nxt;
    logic [15:0] hw_set;
    logic [15:0] hw_clr;
    logic [15:0] sw_val;
    logic        wr_cause;
    logic        illegal_ev;

    assign wr_cause   = reg_req.wr && (reg_req.addr == ADDR_CAUSE_CTRL);
    assign illegal_ev = req_s.illegal_opcode || req_s.uninit_wreg;

    // Hardware set events, one flag per reset type except power-on, which sets two
    assign hw_set = (16'h0000
        | (16'(req_s.trap_conflict) << BIT_TRAP)
        | (16'(illegal_ev)          << BIT_ILLEGAL)
        | (16'(req_s.cfg_mismatch)  << BIT_CFGMIS)
        | (16'(req_s.pin)           << BIT_PIN)
        | (16'(req_s.sw_instr)      << BIT_SWRST)
        | (16'(req_s.watchdog)      << BIT_WDT_TIMEOUT)
        | (16'(power_save_instruction.sleep) << BIT_SLEEP)
        | (16'(power_save_instruction.idle)  << BIT_IDLE)
        | (16'(req_s.brownout || req_s.lp_brownout
               || req_s.poweron) << BIT_BROWN)
        | (16'(req_s.poweron)       << BIT_POWERON));

    // Any power-save instruction clears the watchdog flag
    assign hw_clr = 16'(power_save_instruction.sleep
                        || power_save_instruction.idle)
                    << BIT_WDT_TIMEOUT;

    // Write stores only; no path from here to the reset output
    assign sw_val = wr_cause ? reg_req.wdata : cause_r;

    // Set wins over clear, then unimplemented bits forced low
    assign cause_nxt = ((sw_val & ~hw_clr) | hw_set)
                       & CAUSE_IMPL_MASK;

    always_ff @(posedge mclk) begin
        if (rst) begin
            cause_r <= CAUSE_POR_VAL;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control outputs, forced to defaults by power-on reset only

    logic wdt_en_nxt;

    assign wdt_en_nxt = (watchdog_config_fuse == WDT_FUSE_ALWAYS)
                        || cause_nxt[BIT_SWWDT];

    always_ff @(posedge mclk) begin
        if (rst) begin
            watchdog_enable  <= 1'b0;
            sbor_enable      <= 1'b0;
            retention_enable <= 1'b0;
            pm_sleep_ctrl    <= 1'b0;
        end else begin
            watchdog_enable  <= wdt_en_nxt;
            sbor_enable      <= cause_nxt[BIT_SBOREN];
            retention_enable <= cause_nxt[BIT_RETEN];
            pm_sleep_ctrl    <= cause_nxt[BIT_PMSLP];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port

    logic [15:0] rd_mux;

    assign rd_mux = !reg_req.rd ? 16'h0000 :
        (reg_req.addr == ADDR_CAUSE_CTRL) ? cause_r :
        (reg_req.addr == ADDR_SOURCES)    ? 16'(req_s) : 16'h0000;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    property p_src_reset;
        @(posedge mclk) disable iff (rst)
        any_req |=> master_system_reset;
    endproperty
    a_src_reset: assert property (p_src_reset)
        else $error("source active but master reset low");

    property p_sw_no_reset;
        @(posedge mclk) disable iff (rst)
        (!any_req && stretch_r == 3'h0 && wr_cause)
            |=> !master_system_reset;
    endproperty
    a_sw_no_reset: assert property (p_sw_no_reset)
        else $error("register write caused reset");

    property p_trap_flag;
        @(posedge mclk) disable iff (rst)
        req_s.trap_conflict |=> cause_r[BIT_TRAP];
    endproperty
    a_trap_flag: assert property (p_trap_flag)
        else $error("trap flag not set");

    property p_set_wins;
        @(posedge mclk) disable iff (rst)
        (req_s.pin && wr_cause) |=> cause_r[BIT_PIN];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("software clear beat hardware set");

    property p_timeout_clr;
        @(posedge mclk) disable iff (rst)
        (power_save_instruction.sleep && !req_s.watchdog)
            |=> !cause_r[BIT_WDT_TIMEOUT] && cause_r[BIT_SLEEP];
    endproperty
    a_timeout_clr: assert property (p_timeout_clr)
        else $error("power-save did not update flags");

    property p_unimpl;
        @(posedge mclk) disable iff (rst)
        cause_r[11:10] == 2'h0;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bits set");

    property p_fuse;
        @(posedge mclk) disable iff (rst)
        (watchdog_config_fuse == WDT_FUSE_ALWAYS) |=> watchdog_enable;
    endproperty
    a_fuse: assert property (p_fuse)
        else $error("watchdog off with fuse unprogrammed");

    property p_write_store;
        @(posedge mclk) disable iff (rst)
        (wr_cause && !any_req && !power_save_instruction.sleep
         && !power_save_instruction.idle)
            |=> cause_r == ($past(reg_req.wdata) & CAUSE_IMPL_MASK);
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("written value not stored");

    property p_brown;
        @(posedge mclk) disable iff (rst)
        req_s.brownout |=> cause_r[BIT_BROWN];
    endproperty
    a_brown: assert property (p_brown)
        else $error("brown-out flag not set");

endmodule
